// *** hw/dph_regs.sv ***
// Purpose: Page count and transmit request header register bank on APB.
// Assumes: Engine strobes are one-cycle pulses synchronous to i_clk_sys.
// Notes: No serial-bus reset input; these registers never see one.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dph_regs
   import dph_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_tx_load,
   input wire logic i_rx_load,
   input wire logic [15:0] i_data_size,
   input wire logic i_tx_fetched,
   input wire logic i_rx_fetched,
   output logic [15:0] o_tx_pages_remaining,
   output logic [15:0] o_rx_pages_remaining,
   input wire logic i_hdr_capture,
   input wire logic [1:0] i_hdr_speed,
   input wire logic [5:0] i_hdr_label,
   input wire logic [1:0] i_hdr_retry,
   input wire logic [3:0] i_hdr_tcode,
   input wire logic [3:0] i_hdr_priority,
   input wire logic [15:0] i_hdr_dest_node,
   input wire logic [15:0] i_hdr_offset_upper,
   input wire logic [31:0] i_hdr_offset_lower,
   input wire logic [15:0] i_hdr_length,
   input wire logic [15:0] i_hdr_ext_tcode,
   input wire logic [31:0] i_status_word0,
   input wire logic [31:0] i_status_word1,
   input wire logic [31:0] i_status_word2,
   input wire logic [31:0] i_status_word3,
   output logic o_tx_packetizer_enable,
   output logic [1:0] o_header_view_select,
   output logic [31:0] o_hdr_word0,
   output logic [31:0] o_hdr_word1,
   output logic [31:0] o_hdr_word2,
   output logic [31:0] o_hdr_word3
);
   // =====================================================================
   // State.
   typedef struct packed {
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] w3;
      logic [1:0] view;
      logic pktz;
      logic seen;
   } dph_regs_t;
   dph_regs_t st_ff;
   dph_regs_t nxt_st;

   logic wr_en;
   logic hit;
   logic [31:0] rdata;
   logic [31:0] hdr_view0;
   logic [31:0] hdr_view1;
   logic [31:0] hdr_view2;
   logic [31:0] hdr_view3;
   logic wr_pages;
   logic wr_hdr1;
   logic wr_hdr2;
   logic wr_hdr3;
   logic wr_ctrl;
   logic sw_open;
   logic [1:0] cnt_load;
   logic [1:0] cnt_dec;
   logic [PG_W-1:0] cnt_wr_val [2];
   logic [PG_W-1:0] cnt_val [2];

   // =====================================================================
   // Bus front end.
   dph_apb_slave u_apb (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_hit(hit),
      .i_rdata(rdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .o_prdata(o_prdata),
      .o_wr_en(wr_en)
   );

   // Write strobes per register.
   assign wr_pages = wr_en && (i_paddr == OFS_PAGES);
   assign wr_hdr1 = wr_en && (i_paddr == OFS_HDR1);
   assign wr_hdr2 = wr_en && (i_paddr == OFS_HDR2);
   assign wr_hdr3 = wr_en && (i_paddr == OFS_HDR3);
   assign wr_ctrl = wr_en && (i_paddr == OFS_CTRL);
   // Software may only touch header fields while the packetizer is off.
   assign sw_open = !st_ff.pktz;

   // =====================================================================
   // Page counters: index 0 transmit, index 1 receive.
   assign cnt_load = {i_rx_load, i_tx_load};
   assign cnt_dec = {i_rx_fetched, i_tx_fetched};
   assign cnt_wr_val[0] = i_pwdata[TXPG_LSB +: PG_W];
   assign cnt_wr_val[1] = i_pwdata[RXPG_LSB +: PG_W];

   for (genvar g = 0; g < 2; g++)
   begin : g_cnt
      dph_page_counter u_cnt (
         .i_clk_sys(i_clk_sys),
         .i_rst(i_rst),
         .i_load(cnt_load[g]),
         .i_load_val(i_data_size),
         .i_wr(wr_pages),
         .i_wr_val(cnt_wr_val[g]),
         .i_dec(cnt_dec[g]),
         .o_count(cnt_val[g])
      );
   end

   assign o_tx_pages_remaining = cnt_val[0];
   assign o_rx_pages_remaining = cnt_val[1];

   // =====================================================================
   // Read mux; the view select swaps the whole E8h to F4h window.
   always_comb
   begin
      hdr_view0 = 32'h00000000;
      hdr_view1 = 32'h00000000;
      hdr_view2 = 32'h00000000;
      hdr_view3 = 32'h00000000;
      case (st_ff.view)
         VIEW_WRREQ:
         begin
            hdr_view0 = st_ff.w0;
            hdr_view1 = st_ff.w1;
            hdr_view2 = st_ff.w2;
            hdr_view3 = st_ff.w3;
         end
         VIEW_STATUS:
         begin
            hdr_view0 = i_status_word0;
            hdr_view1 = i_status_word1;
            hdr_view2 = i_status_word2;
            hdr_view3 = i_status_word3;
         end
         default:
         begin
            hdr_view0 = 32'h00000000;
         end
      endcase
   end

   // Address decode; anything else is unmapped and errors on the bus.
   always_comb
   begin
      hit = 1'b1;
      rdata = 32'h00000000;
      case (i_paddr)
         OFS_PAGES: rdata = {cnt_val[0], cnt_val[1]};
         OFS_HDR0: rdata = hdr_view0;
         OFS_HDR1: rdata = hdr_view1;
         OFS_HDR2: rdata = hdr_view2;
         OFS_HDR3: rdata = hdr_view3;
         OFS_CTRL: rdata = {29'h00000000, st_ff.pktz, st_ff.view};
         default: hit = 1'b0;
      endcase
   end

   // =====================================================================
   // Header state. Capture from the transmit path wins over a software write
   // in the same cycle, because losing a real header would be worse.
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.seen = 1'b1;
      if (wr_ctrl)
      begin
         nxt_st.view = i_pwdata[VIEW_LSB +: 2];
         nxt_st.pktz = i_pwdata[PKTZ_BIT];
      end
      // Software writes to the open fields only.
      if (wr_hdr1 && sw_open)
         nxt_st.w1[OFSU_LSB +: 16] = i_pwdata[OFSU_LSB +: 16];
      if (wr_hdr2 && sw_open)
         nxt_st.w2 = i_pwdata;
      if (wr_hdr3 && sw_open)
      begin
         nxt_st.w3[LEN_LSB +: 16] = i_pwdata[LEN_LSB +: 16];
         nxt_st.w3[EXT_LSB +: 16] = i_pwdata[EXT_LSB +: 16];
      end
      // Read-only fields follow the request actually sent.
      if (i_hdr_capture)
      begin
         nxt_st.w0[SPD_LSB +: 2] = i_hdr_speed;
         nxt_st.w0[LBL_LSB +: 6] = i_hdr_label;
         nxt_st.w0[RTY_LSB +: 2] = i_hdr_retry;
         nxt_st.w0[TCD_LSB +: 4] = i_hdr_tcode;
         nxt_st.w0[PRI_LSB +: 4] = i_hdr_priority;
         nxt_st.w1[NODE_LSB +: 16] = i_hdr_dest_node;
         nxt_st.w1[OFSU_LSB +: 16] = i_hdr_offset_upper;
         nxt_st.w2 = i_hdr_offset_lower;
         nxt_st.w3[LEN_LSB +: 16] = i_hdr_length;
         nxt_st.w3[EXT_LSB +: 16] = i_hdr_ext_tcode;
      end
      // A running packetizer always sends write requests.
      if (st_ff.pktz)
         nxt_st.w0[TCD_LSB +: 4] = TCODE_WRREQ;
      // Reserved bits stay zero whatever the capture carries.
      nxt_st.w0[31:18] = 14'h0000;
   end

   // Reset only; these flops have no serial-bus reset path.
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_ff.w0 <= RST_HDR0;
         st_ff.w1 <= RST_HDR1;
         st_ff.w2 <= RST_HDR2;
         st_ff.w3 <= RST_HDR3;
         st_ff.view <= RST_CTRL[VIEW_LSB +: 2];
         st_ff.pktz <= RST_CTRL[PKTZ_BIT];
         st_ff.seen <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs toward the packetizer.
   assign o_tx_packetizer_enable = st_ff.pktz;
   assign o_header_view_select = st_ff.view;
   assign o_hdr_word0 = st_ff.w0;
   assign o_hdr_word1 = st_ff.w1;
   assign o_hdr_word2 = st_ff.w2;
   assign o_hdr_word3 = st_ff.w3;

   // =====================================================================
   // Assertions.
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   sequence s_rd_hdr0_setup;
      i_psel && !i_penable && !i_pwrite && (i_paddr == OFS_HDR0);
   endsequence

   sequence s_access;
      i_psel && i_penable;
   endsequence

   a_reset_values: assert property (
      !st_ff.seen |-> (st_ff.w0 == RST_HDR0) && (st_ff.w3 == RST_HDR3)
         && (st_ff.w1 == RST_HDR1) && ({cnt_val[0], cnt_val[1]} == RST_PAGES))
      else $error("Registers left reset with wrong values.");

   a_tx_count_load: assert property (
      i_tx_load |=> (o_tx_pages_remaining == $past(i_data_size)))
      else $error("Transmit page count did not load data size.");

   a_rx_count_load: assert property (
      i_rx_load |=> (o_rx_pages_remaining == $past(i_data_size)))
      else $error("Receive page count did not load data size.");

   a_tx_count_dec: assert property (
      i_tx_fetched && !i_tx_load && !wr_pages && (o_tx_pages_remaining != 16'h0000)
      |=> (o_tx_pages_remaining == $past(o_tx_pages_remaining) - 16'h0001))
      else $error("Transmit page count did not decrement on fetch.");

   a_rx_count_dec: assert property (
      i_rx_fetched && !i_rx_load && !wr_pages && (o_rx_pages_remaining != 16'h0000)
      |=> (o_rx_pages_remaining == $past(o_rx_pages_remaining) - 16'h0001))
      else $error("Receive page count did not decrement on fetch.");

   a_wrreq_view_read: assert property (
      s_rd_hdr0_setup ##0 (st_ff.view == VIEW_WRREQ) ##1 s_access
      |-> (o_prdata == $past(st_ff.w0)))
      else $error("Header view did not return the request header.");

   a_status_view_read: assert property (
      s_rd_hdr0_setup ##0 (st_ff.view == VIEW_STATUS) ##1 s_access
      |-> (o_prdata == $past(i_status_word0)))
      else $error("Status view did not return packetizer status.");

   a_ro_fields_hold: assert property (
      !i_hdr_capture |=> $stable(st_ff.w0[SPD_LSB +: 2]) && $stable(st_ff.w0[LBL_LSB +: 6])
         && $stable(st_ff.w0[RTY_LSB +: 2]) && $stable(st_ff.w0[PRI_LSB +: 4]))
      else $error("Read-only header field changed without a capture.");

   a_tcode_forced: assert property (
      st_ff.pktz |=> (st_ff.w0[TCD_LSB +: 4] == TCODE_WRREQ))
      else $error("Transaction code not forced while packetizer runs.");

   a_locked_offset: assert property (
      st_ff.pktz && !i_hdr_capture |=> $stable(st_ff.w2) && $stable(st_ff.w3))
      else $error("Locked header field changed while packetizer runs.");

   a_open_offset_write: assert property (
      wr_hdr2 && sw_open && !i_hdr_capture |=> (st_ff.w2 == $past(i_pwdata)))
      else $error("Open lower offset did not take the software write.");

   a_ext_capture: assert property (
      i_hdr_capture |=> (st_ff.w3[EXT_LSB +: 16] == $past(i_hdr_ext_tcode))
         && (st_ff.w1[NODE_LSB +: 16] == $past(i_hdr_dest_node)))
      else $error("Captured header fields not stored.");

   // The first header word takes no software write, even while the other fields are open.
   a_hdr0_write_ignored: assert property (
      wr_en && (i_paddr == OFS_HDR0) && !i_hdr_capture && !st_ff.pktz |=> $stable(st_ff.w0))
      else $error("Read-only first header word changed on a write.");

   // The destination node is read-only even while software may edit the rest.
   a_dest_node_ro: assert property (
      wr_hdr1 && !i_hdr_capture |=> $stable(st_ff.w1[NODE_LSB +: 16]))
      else $error("Destination node changed on a software write.");

   a_upper_offset_write: assert property (
      wr_hdr1 && sw_open && !i_hdr_capture
      |=> (st_ff.w1[OFSU_LSB +: 16] == $past(i_pwdata[OFSU_LSB +: 16])))
      else $error("Open upper offset did not take the software write.");

   a_length_write: assert property (
      wr_hdr3 && sw_open && !i_hdr_capture |=> (st_ff.w3 == $past(i_pwdata)))
      else $error("Open length and extended code did not take the write.");

   a_locked_upper: assert property (
      st_ff.pktz && !i_hdr_capture |=> $stable(st_ff.w1))
      else $error("Second header word changed while packetizer runs.");
endmodule : dph_regs
`default_nettype wire

// *** hw/dph_pkg.sv ***
// Purpose: Constants shared by the page count and transmit header register bank.
// Assumes: Field positions counted with bit 0 as the least significant bit of the bus word.
// Notes: Layout bit n of the quadlet drawing maps to bus bit 31-n.
// Behaviour
// - Page count register resets to zero and ignores serial-bus resets.
// - Upper half holds transmit pages still to fetch, loaded from data_size.
// - Lower half holds receive pages still to fetch, loaded from data_size.
// - Each page fetch decrements the matching transmit or receive count.
// - View select 00 shows the write request header at E8h to F4h.
// - Header registers reset to zero unless noted, bus resets ignored.
// - First header register resets to 0001 0010h.
// - Speed code field is read-only, defaults to 1h.
// - Transaction label field is read-only.
// - Retry code field is read-only.
// - Transaction code defaults to 1h and is forced to 1h while packetizer runs.
// - Priority field is read-only.
// - Second header register upper half carries destination node.
// - Second header register lower half carries upper destination offset.
// - Third header register carries lower destination offset.
// - Fourth header register resets to 0008 0000h, length defaults to 8h.
// - Fourth header register lower half carries extended transaction code.
// - View select 01 shows packetizer status words at the same addresses.
package dph_pkg;
   // =====================================================================
   // Register offsets.
   localparam logic [11:0] OFS_PAGES = 12'h0E4;
   localparam logic [11:0] OFS_HDR0 = 12'h0E8;
   localparam logic [11:0] OFS_HDR1 = 12'h0EC;
   localparam logic [11:0] OFS_HDR2 = 12'h0F0;
   localparam logic [11:0] OFS_HDR3 = 12'h0F4;
   localparam logic [11:0] OFS_CTRL = 12'h0FC;
   // =====================================================================
   // Reset values.
   localparam logic [31:0] RST_PAGES = 32'h00000000;
   localparam logic [31:0] RST_HDR0 = 32'h00010010;
   localparam logic [31:0] RST_HDR1 = 32'h00000000;
   localparam logic [31:0] RST_HDR2 = 32'h00000000;
   localparam logic [31:0] RST_HDR3 = 32'h00080000;
   localparam logic [2:0] RST_CTRL = 3'h0;
   // =====================================================================
   // Field positions and widths.
   localparam int PG_W = 16;
   localparam int TXPG_LSB = 16;
   localparam int RXPG_LSB = 0;
   localparam int SPD_LSB = 16;
   localparam int LBL_LSB = 10;
   localparam int RTY_LSB = 8;
   localparam int TCD_LSB = 4;
   localparam int PRI_LSB = 0;
   localparam int NODE_LSB = 16;
   localparam int OFSU_LSB = 0;
   localparam int LEN_LSB = 16;
   localparam int EXT_LSB = 0;
   localparam int VIEW_LSB = 0;
   localparam int PKTZ_BIT = 2;
   // =====================================================================
   // Codes.
   localparam logic [1:0] VIEW_WRREQ = 2'h0;
   localparam logic [1:0] VIEW_STATUS = 2'h1;
   localparam logic [3:0] TCODE_WRREQ = 4'h1;
endpackage : dph_pkg

// *** hw/dph_page_counter.sv ***
// Purpose: One page-table entry counter with load, software write and decrement.
// Assumes: Loads carry a nonzero count.
// Notes: Counter saturates at zero so a stray fetch cannot wrap it.
`timescale 1ns/1ps
`default_nettype none
module dph_page_counter
   import dph_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [PG_W-1:0] i_load_val,
   input wire logic i_wr,
   input wire logic [PG_W-1:0] i_wr_val,
   input wire logic i_dec,
   output logic [PG_W-1:0] o_count
);
   // =====================================================================
   // State.
   typedef struct packed {
      logic [PG_W-1:0] count;
   } dph_cnt_t;
   dph_cnt_t st_ff;
   dph_cnt_t nxt_st;
   logic [PG_W-1:0] base;

   // A new command load wins; a fetch in the same cycle as a write still counts.
   always_comb
   begin
      nxt_st = st_ff;
      base = i_wr ? i_wr_val : st_ff.count;
      if (i_load)
      begin
         nxt_st.count = i_load_val;
      end
      else if (i_dec && (base != '0))
      begin
         nxt_st.count = base - {{(PG_W-1){1'b0}}, 1'b1};
      end
      else
      begin
         nxt_st.count = base;
      end
   end

   // Reset value zero; no serial-bus reset input exists on purpose.
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign o_count = st_ff.count;
endmodule : dph_page_counter
`default_nettype wire

// *** hw/dph_apb_slave.sv ***
// Purpose: APB slave front end with a registered read path.
// Assumes: Read data for the setup address is presented combinationally by the bank.
// Notes: No wait states; unmapped access answers with pslverr.
`timescale 1ns/1ps
`default_nettype none
module dph_apb_slave
   import dph_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic i_hit,
   input wire logic [31:0] i_rdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   output logic o_wr_en
);
   // =====================================================================
   // State.
   typedef struct packed {
      logic [31:0] prdata;
   } dph_apb_t;
   dph_apb_t st_ff;
   dph_apb_t nxt_st;

   // Read data is caught in the setup cycle so the access phase sees a flop.
   always_comb
   begin
      nxt_st = st_ff;
      if (i_psel && !i_penable && !i_pwrite)
         nxt_st.prdata = i_hit ? i_rdata : 32'h00000000;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // Handshake answers in the first access cycle.
   assign o_pready = i_psel && i_penable;
   assign o_pslverr = i_psel && i_penable && !i_hit;
   assign o_wr_en = i_psel && i_penable && i_pwrite && i_hit;
   assign o_prdata = st_ff.prdata;
endmodule : dph_apb_slave
`default_nettype wire

// *** tb/tb_dph_regs.sv ***
// Purpose: Self-checking bench for the page count and transmit header register bank.
// Assumes: Zero-wait APB slave; engine strobes are one-cycle pulses.
// Notes: Every input is driven by non-blocking assignment right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_dph_regs;
   import dph_pkg::*;
   // ==========================================================================
   // Stimulus and observation signals.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic pready, pslverr, pktz;
   logic [31:0] prdata, hw0, hw1, hw2, hw3;
   logic txl = 1'b0, rxl = 1'b0, txf = 1'b0, rxf = 1'b0, cap = 1'b0;
   logic [15:0] dsize = 16'h0000;
   logic [1:0] hspd = 2'h0;
   logic [5:0] hlbl = 6'h00;
   logic [15:0] hnode = 16'h0000;
   logic [15:0] hlen = 16'h0000;
   logic [15:0] txc, rxc;
   logic [1:0] view;
   logic [31:0] st [4] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
   int err_count = 0;
   int num_checks = 0;
   logic [31:0] rd;
   logic er;

   // The bench clock runs at 100 MHz.
   always #5 clk = ~clk;

   dph_regs dut_u (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_tx_load(txl), .i_rx_load(rxl),
      .i_data_size(dsize), .i_tx_fetched(txf), .i_rx_fetched(rxf),
      .o_tx_pages_remaining(txc), .o_rx_pages_remaining(rxc), .i_hdr_capture(cap),
      .i_hdr_speed(hspd), .i_hdr_label(hlbl), .i_hdr_retry(2'h3), .i_hdr_tcode(4'hA),
      .i_hdr_priority(4'h5), .i_hdr_dest_node(hnode), .i_hdr_offset_upper(dsize),
      .i_hdr_offset_lower(32'h89ABCDEF), .i_hdr_length(hlen),
      .i_hdr_ext_tcode(16'h0002), .i_status_word0(st[0]), .i_status_word1(st[1]),
      .i_status_word2(st[2]), .i_status_word3(st[3]), .o_tx_packetizer_enable(pktz),
      .o_header_view_select(view), .o_hdr_word0(hw0), .o_hdr_word1(hw1),
      .o_hdr_word2(hw2), .o_hdr_word3(hw3));

   // ==========================================================================
   // Comparison and reporting tasks.
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   // One APB transfer; waits for pready under a bound and samples at that edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      if (n >= 50)
         chk_bit(pready, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Reads a register and compares its word and its error flag.
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000, rd, er);
      chk_word(rd, exp);
      chk_bit(er, 1'b0);
   endtask : rd_chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask : wr

   // ==========================================================================
   // Scenarios.
   task automatic test_reset();
      rd_chk(OFS_PAGES, 32'h00000000);
      rd_chk(OFS_HDR0, 32'h00010010);
      rd_chk(OFS_HDR1, 32'h00000000);
      rd_chk(OFS_HDR2, 32'h00000000);
      rd_chk(OFS_HDR3, 32'h00080000);
      chk_word(hw0, 32'h00010010);
      $display("test reset done");
   endtask : test_reset

   // Loads both counts, then fetch strobes back to back, one cycle overlapping.
   task automatic test_counts();
      txl <= 1'b1;
      dsize <= 16'h0005;
      @(posedge clk);
      txl <= 1'b0;
      rxl <= 1'b1;
      dsize <= 16'h0003;
      @(posedge clk);
      rxl <= 1'b0;
      txf <= 1'b1;
      @(negedge clk);
      chk_word({16'h0000, txc}, 32'h00000005);
      @(posedge clk);
      rxf <= 1'b1;
      @(negedge clk);
      chk_word({16'h0000, rxc}, 32'h00000003);
      @(posedge clk);
      txf <= 1'b0;
      rxf <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk_word({txc, rxc}, 32'h00030002);
      @(posedge clk);
      rd_chk(OFS_PAGES, 32'h00030002);
      wr(OFS_PAGES, 32'h00070009);
      rd_chk(OFS_PAGES, 32'h00070009);
      $display("test counts done");
   endtask : test_counts

   // Captures a header with the packetizer off, then edits the writable fields.
   task automatic test_header();
      dsize <= 16'hABCD;
      hspd <= 2'h2;
      hlbl <= 6'h2A;
      hnode <= 16'h1234;
      hlen <= 16'h0040;
      cap <= 1'b1;
      @(posedge clk);
      cap <= 1'b0;
      @(posedge clk);
      rd_chk(OFS_HDR0, {14'h0, 2'h2, 6'h2A, 2'h3, 4'hA, 4'h5});
      rd_chk(OFS_HDR1, 32'h1234ABCD);
      rd_chk(OFS_HDR2, 32'h89ABCDEF);
      rd_chk(OFS_HDR3, 32'h00400002);
      wr(OFS_HDR0, 32'hFFFFFFFF);
      wr(OFS_HDR1, 32'h55551111);
      wr(OFS_HDR2, 32'h01234567);
      wr(OFS_HDR3, 32'h00200003);
      rd_chk(OFS_HDR0, {14'h0, 2'h2, 6'h2A, 2'h3, 4'hA, 4'h5});
      rd_chk(OFS_HDR1, 32'h12341111);
      rd_chk(OFS_HDR2, 32'h01234567);
      rd_chk(OFS_HDR3, 32'h00200003);
      chk_word(hw2, 32'h01234567);
      chk_word(hw1, 32'h12341111);
      chk_word(hw3, 32'h00200003);
      $display("test header done");
   endtask : test_header

   // With the packetizer on, tcode is forced and edits are refused.
   task automatic test_packetizer();
      wr(OFS_CTRL, 32'h00000004);
      chk_bit(pktz, 1'b1);
      @(posedge clk);
      rd_chk(OFS_HDR0, {14'h0, 2'h2, 6'h2A, 2'h3, 4'h1, 4'h5});
      wr(OFS_HDR1, 32'h0000EEEE);
      wr(OFS_HDR2, 32'h00000000);
      wr(OFS_HDR3, 32'hFFFFFFFF);
      rd_chk(OFS_HDR1, 32'h12341111);
      rd_chk(OFS_HDR2, 32'h01234567);
      rd_chk(OFS_HDR3, 32'h00200003);
      $display("test packetizer done");
   endtask : test_packetizer

   // View 01 swaps in the status words; view 10 reads zero; unmapped errs.
   task automatic test_views();
      st <= '{32'hA0000001, 32'hB0000002, 32'hC0000003, 32'hD0000004};
      wr(OFS_CTRL, 32'h00000001);
      chk_word({30'h0, view}, 32'h00000001);
      rd_chk(OFS_HDR0, 32'hA0000001);
      rd_chk(OFS_HDR1, 32'hB0000002);
      rd_chk(OFS_HDR2, 32'hC0000003);
      rd_chk(OFS_HDR3, 32'hD0000004);
      wr(OFS_CTRL, 32'h00000002);
      rd_chk(OFS_HDR0, 32'h00000000);
      wr(OFS_CTRL, 32'h00000000);
      rd_chk(OFS_HDR2, 32'h01234567);
      apb(1'b0, 12'h100, 32'h00000000, rd, er);
      chk_bit(er, 1'b1);
      chk_word(rd, 32'h00000000);
      $display("test views done");
   endtask : test_views

   // ==========================================================================
   // Main sequence: reset for 8 cycles, then every scenario in turn.
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      test_reset();
      test_counts();
      test_header();
      test_packetizer();
      test_views();
      conclude();
   end

   // Watchdog: the scenarios need well under 1000 cycles.
   initial
   begin
      #200000;
      err_count++;
      conclude();
   end
endmodule : tb_dph_regs
`default_nettype wire
